// [core/srs_regs.svh]
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SRS_ADDR_W          8
`define SRS_OFS_START_SEL   8'h17
`define SRS_OFS_CONV_SRC    8'h18

// ----------------------------------------
// reset values
// ----------------------------------------
`define SRS_START_SEL_RST   8'h04
`define SRS_CONV_SRC_RST    8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define SRS_RSVD_LSB        4
`define SRS_SECOND_ST_LSB   2
`define SRS_FIRST_ST_LSB    0
`define SRS_CH1_SRC_LSB     4
`define SRS_CH0_SRC_LSB     0

// ----------------------------------------
// slot counts per frame
// ----------------------------------------
`define SRS_SLOTS_STEREO    4'h2
`define SRS_SLOTS_TDM4      4'h4
`define SRS_SLOTS_TDM8      4'h8

`endif

// [core/srs_pkg.sv]
`default_nettype none

package srs_pkg;

	// slot arrangement of the serial output port
	typedef enum logic [1:0] {
		SRS_SLOT_STEREO = 2'b00,
		SRS_SLOT_TDM4   = 2'b01,
		SRS_SLOT_TDM8   = 2'b10,
		SRS_SLOT_RSVD   = 2'b11
	} srs_slot_mode_e;

	// class of source feeding an output rate converter channel
	typedef enum logic [1:0] {
		SRS_SRC_CORE   = 2'b00,
		SRS_SRC_ADC    = 2'b01,
		SRS_SRC_SERIAL = 2'b10
	} srs_src_class_e;

	// decoded converter source
	typedef struct packed {
		srs_src_class_e src_class;
		logic [2:0]     index;
	} srs_src_sel_s;

	// routing fields as seen by the datapath
	typedef struct packed {
		logic [1:0] second_output_pin_start_channel;
		logic [1:0] first_output_pin_start_channel;
		logic [3:0] out_converter_ch1_source;
		logic [3:0] out_converter_ch0_source;
	} srs_route_s;

	// per pin slot walker state
	typedef struct packed {
		logic       active;
		logic [2:0] slot;
		logic [1:0] start;
	} srs_pin_s;

endpackage

`default_nettype wire

// [core/srs_src_mux.sv]
`timescale 1ns/1ps
`default_nettype none

module srs_src_mux
	import srs_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	// source select code
	input  wire logic [3:0]            code_i,
	// candidate sources
	input  wire logic [4*SAMPLE_W-1:0] core_out_i,
	input  wire logic [4*SAMPLE_W-1:0] adc_i,
	input  wire logic [8*SAMPLE_W-1:0] serial_in_i,
	// selected sample and its decoded source
	output logic      [SAMPLE_W-1:0]   sample_o,
	output srs_src_sel_s               sel_o
);

	// ----------------------------------------
	// code decode
	// ----------------------------------------

	// 0xxx: core/adc group, 1xxx: serial input 0-7
	always_comb begin
		sel_o = '0;
		sample_o = '0;
		if (code_i[3]) begin
			sel_o.src_class = SRS_SRC_SERIAL;
			sel_o.index = code_i[2:0];
			sample_o = serial_in_i[code_i[2:0]*SAMPLE_W +: SAMPLE_W];
		end else if (code_i[2]) begin
			sel_o.src_class = SRS_SRC_ADC;
			sel_o.index = {1'b0, code_i[1:0]};
			sample_o = adc_i[code_i[1:0]*SAMPLE_W +: SAMPLE_W];
		end else begin
			sel_o.src_class = SRS_SRC_CORE;
			sel_o.index = {1'b0, code_i[1:0]};
			sample_o = core_out_i[code_i[1:0]*SAMPLE_W +: SAMPLE_W];
		end
	end

endmodule

`default_nettype wire

// [core/srs_top.sv]
// Notes on behaviour
// - start-select bits 3:2 pick second pin start channel 0/2/4/6, reset 01.
// - start-select bits 1:0 pick first pin start channel 0/2/4/6, reset 00.
// - each pin emits following channels in order, count set by slot arrangement.
// - source bits 7:4 route core 0-3, adc 0-3 or serial 0-7 to converter ch1.
// - source bits 3:0 route the same sources to converter ch0, reset core 0.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "srs_regs.svh"

module srs_top
	import srs_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_b_i,
	// register port
	input  wire logic [`SRS_ADDR_W-1:0]    reg_addr_i,
	input  wire logic [7:0]                reg_wdata_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	output logic      [7:0]                reg_rdata_o,
	// serial output port timing, same clock domain
	input  wire logic [1:0]                slot_arrangement_setting_i,
	input  wire logic                      frame_start_i,
	input  wire logic                      slot_strobe_i,
	input  wire logic [8*SAMPLE_W-1:0]     slot_data_i,
	// serial output pins
	output logic      [SAMPLE_W-1:0]       first_serial_output_pin_o,
	output logic      [SAMPLE_W-1:0]       second_serial_output_pin_o,
	output logic      [1:0]                pin_valid_o,
	output logic      [5:0]                pin_channel_o,
	// converter sources
	input  wire logic [4*SAMPLE_W-1:0]     core_out_i,
	input  wire logic [4*SAMPLE_W-1:0]     adc_i,
	input  wire logic [8*SAMPLE_W-1:0]     serial_in_i,
	// converter channel samples and routing state
	output logic      [2*SAMPLE_W-1:0]     conv_sample_o,
	output srs_src_sel_s [1:0]             conv_src_o,
	output srs_route_s                     route_o
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------

	generate
		if (SAMPLE_W < 1 || SAMPLE_W > 32) begin : g_bad_width
			$error("srs_top: SAMPLE_W must lie in 1..32");
		end
		// the walker counts slots in three bits, eight at most
		if (`SRS_SLOTS_TDM8 > 4'h8 || `SRS_SLOTS_STEREO < 4'h1) begin : g_bad_slots
			$error("srs_top: slot counts must lie in 1..8");
		end
		// reserved nibble of the start select must come up zero
		if ((`SRS_START_SEL_RST >> `SRS_RSVD_LSB) != 8'h00) begin : g_bad_rsvd
			$error("srs_top: reserved start select bits must reset to zero");
		end
		// both start fields sit below the reserved nibble
		if (`SRS_SECOND_ST_LSB + 2 > `SRS_RSVD_LSB || `SRS_FIRST_ST_LSB + 2 > `SRS_SECOND_ST_LSB) begin : g_bad_start
			$error("srs_top: start select fields overlap");
		end
		// both source nibbles fit the byte without overlap
		if (`SRS_CH1_SRC_LSB + 4 > 8 || `SRS_CH0_SRC_LSB + 4 > `SRS_CH1_SRC_LSB) begin : g_bad_src
			$error("srs_top: converter source fields overlap");
		end
	endgenerate

	// ----------------------------------------
	// register file
	// ----------------------------------------

	logic [7:0] serial_out_start_channel_select;
	logic [7:0] out_rate_converter_source_0_1;
	logic [7:0] next_serial_out_start_channel_select;
	logic [7:0] next_out_rate_converter_source_0_1;
	logic [7:0] next_reg_rdata;

	// write decode and read mux; whole byte stored, reserved bits too
	always_comb begin
		next_serial_out_start_channel_select = serial_out_start_channel_select;
		next_out_rate_converter_source_0_1 = out_rate_converter_source_0_1;
		next_reg_rdata = 8'h00;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`SRS_OFS_START_SEL: begin
					next_serial_out_start_channel_select = reg_wdata_i;
				end
				`SRS_OFS_CONV_SRC: begin
					next_out_rate_converter_source_0_1 = reg_wdata_i;
				end
				default: begin
					next_reg_rdata = 8'h00;
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`SRS_OFS_START_SEL: begin
					next_reg_rdata = serial_out_start_channel_select;
				end
				`SRS_OFS_CONV_SRC: begin
					next_reg_rdata = out_rate_converter_source_0_1;
				end
				default: begin
					next_reg_rdata = 8'h00; // unmapped reads as zero
				end
			endcase
		end
	end

	// register state, read data valid one cycle after the strobe only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			serial_out_start_channel_select <= `SRS_START_SEL_RST;
			out_rate_converter_source_0_1 <= `SRS_CONV_SRC_RST;
			reg_rdata_o <= 8'h00;
		end else begin
			serial_out_start_channel_select <= next_serial_out_start_channel_select;
			out_rate_converter_source_0_1 <= next_out_rate_converter_source_0_1;
			reg_rdata_o <= next_reg_rdata;
		end
	end

	// ----------------------------------------
	// field extraction
	// ----------------------------------------

	// reserved nibble deliberately left out of the route
	always_comb begin
		route_o.second_output_pin_start_channel =
			serial_out_start_channel_select[`SRS_SECOND_ST_LSB +: 2];
		route_o.first_output_pin_start_channel =
			serial_out_start_channel_select[`SRS_FIRST_ST_LSB +: 2];
		route_o.out_converter_ch1_source =
			out_rate_converter_source_0_1[`SRS_CH1_SRC_LSB +: 4];
		route_o.out_converter_ch0_source =
			out_rate_converter_source_0_1[`SRS_CH0_SRC_LSB +: 4];
	end

	// ----------------------------------------
	// slot arrangement
	// ----------------------------------------

	// slots per frame; the reserved code falls back to eight
	function automatic logic [3:0] slot_count(input logic [1:0] mode);
		logic [3:0] cnt;
		cnt = `SRS_SLOTS_TDM8;
		unique case (srs_slot_mode_e'(mode))
			SRS_SLOT_STEREO: cnt = `SRS_SLOTS_STEREO;
			SRS_SLOT_TDM4:   cnt = `SRS_SLOTS_TDM4;
			SRS_SLOT_TDM8:   cnt = `SRS_SLOTS_TDM8;
			default:         cnt = `SRS_SLOTS_TDM8;
		endcase
		return cnt;
	endfunction

	logic [3:0] last_slot;

	// index of the final slot of a frame
	assign last_slot = slot_count(slot_arrangement_setting_i) - 4'h1;

	// ----------------------------------------
	// channel helpers
	// ----------------------------------------

	// start code picks an even channel
	function automatic logic [2:0] start_chan(input logic [1:0] start);
		return {start, 1'b0};
	endfunction

	// one channel's sample out of the slot bus
	function automatic logic [SAMPLE_W-1:0] slot_sample(
		input logic [8*SAMPLE_W-1:0] data,
		input logic [2:0]            idx
	);
		return data[idx*SAMPLE_W +: SAMPLE_W];
	endfunction

	// ----------------------------------------
	// per pin slot walkers
	// ----------------------------------------

	logic [1:0]          pin_start [2];
	logic [SAMPLE_W-1:0] pin_sample [2];

	assign pin_start[0] = route_o.first_output_pin_start_channel;
	assign pin_start[1] = route_o.second_output_pin_start_channel;

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pin
			srs_pin_s            walk;
			srs_pin_s            next_walk;
			logic [2:0]          chan;
			logic [2:0]          next_chan;
			logic [SAMPLE_W-1:0] sample;
			logic [SAMPLE_W-1:0] next_sample;
			logic                valid;
			logic                next_valid;

			// start latched per frame so a mid-frame write cannot tear it
			always_comb begin
				next_walk = walk;
				next_chan = chan;
				next_sample = sample;
				next_valid = 1'b0;
				if (frame_start_i) begin
					next_walk.active = 1'b1;
					next_walk.slot = 3'h0;
					next_walk.start = pin_start[p];
					next_chan = start_chan(pin_start[p]);
					next_sample = slot_sample(slot_data_i, start_chan(pin_start[p]));
					next_valid = 1'b1;
				end else if (slot_strobe_i && walk.active) begin
					if ({1'b0, walk.slot} == last_slot) begin
						next_walk.active = 1'b0; // frame's slots used up
					end else begin
						next_walk.slot = walk.slot + 3'h1;
						next_chan = start_chan(walk.start) + next_walk.slot;
						next_sample = slot_sample(slot_data_i, next_chan);
						next_valid = 1'b1;
					end
				end
			end

			// walker registers
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					walk <= '0;
					chan <= 3'h0;
					sample <= '0;
					valid <= 1'b0;
				end else begin
					walk <= next_walk;
					chan <= next_chan;
					sample <= next_sample;
					valid <= next_valid;
				end
			end

			assign pin_sample[p] = sample;
			assign pin_valid_o[p] = valid;
			assign pin_channel_o[p*3 +: 3] = chan;
		end
	endgenerate

	// pin data straight from the walker flops
	assign first_serial_output_pin_o = pin_sample[0];
	assign second_serial_output_pin_o = pin_sample[1];

	// ----------------------------------------
	// converter source routing
	// ----------------------------------------

	logic [3:0]          conv_code [2];
	logic [SAMPLE_W-1:0] mux_sample [2];
	srs_src_sel_s        mux_sel [2];

	assign conv_code[0] = route_o.out_converter_ch0_source;
	assign conv_code[1] = route_o.out_converter_ch1_source;

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_conv
			logic [SAMPLE_W-1:0] next_conv;
			srs_src_sel_s        next_src;

			srs_src_mux #(
				.SAMPLE_W (SAMPLE_W)
			) u_mux (
				.code_i      (conv_code[c]),
				.core_out_i  (core_out_i),
				.adc_i       (adc_i),
				.serial_in_i (serial_in_i),
				.sample_o    (mux_sample[c]),
				.sel_o       (mux_sel[c])
			);

			// selected source, one cycle of latency
			always_comb begin
				next_conv = mux_sample[c];
				next_src = mux_sel[c];
			end

			// converter sample registers
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					conv_sample_o[c*SAMPLE_W +: SAMPLE_W] <= '0;
					conv_src_o[c] <= '0;
				end else begin
					conv_sample_o[c*SAMPLE_W +: SAMPLE_W] <= next_conv;
					conv_src_o[c] <= next_src;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// [verification/srs_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// routing checker
// --------------------------------
module srs_checker
	import srs_pkg::*;
(
	// clock and reset
	input wire logic               clk_i,
	input wire logic               rst_b_i,
	// register port
	input wire logic [7:0]         reg_addr_i,
	input wire logic [7:0]         reg_wdata_i,
	input wire logic               reg_wr_i,
	input wire logic               reg_rd_i,
	input wire logic [7:0]         reg_rdata_o,
	// slot timing and pins
	input wire logic [1:0]         slot_arrangement_setting_i,
	input wire logic               frame_start_i,
	input wire logic               slot_strobe_i,
	input wire logic [1:0]         pin_valid_o,
	input wire logic [5:0]         pin_channel_o,
	// routing state
	input wire srs_src_sel_s [1:0] conv_src_o,
	input wire srs_route_s         route_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// decoded register writes
	wire logic wr_start = reg_wr_i && reg_addr_i == 8'h17;
	wire logic wr_src   = reg_wr_i && reg_addr_i == 8'h18;

	a_second_start: assert property (wr_start |=>
		route_o.second_output_pin_start_channel == $past(reg_wdata_i[3:2])) else $error("second start not stored");
	a_first_start: assert property (wr_start |=>
		route_o.first_output_pin_start_channel == $past(reg_wdata_i[1:0])) else $error("first start not stored");
	a_ch1_src_wr: assert property (wr_src |=>
		route_o.out_converter_ch1_source == $past(reg_wdata_i[7:4])) else $error("ch1 source not stored");
	a_rsvd_readback: assert property (wr_start ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 8'h17) |=>
		reg_rdata_o == $past(reg_wdata_i, 3)) else $error("start select readback wrong");
	a_ch0_serial: assert property (route_o.out_converter_ch0_source[3] |=>
		conv_src_o[0] == {2'b10, $past(route_o.out_converter_ch0_source[2:0])}) else $error("ch0 serial decode");
	a_frame_first: assert property (frame_start_i |=> pin_valid_o == 2'b11 &&
		pin_channel_o[2:0] == {$past(route_o.first_output_pin_start_channel), 1'b0}) else $error("first pin start");
	a_slot_step: assert property (frame_start_i ##1 (slot_strobe_i && !frame_start_i) |=>
		pin_valid_o[0] && pin_channel_o[2:0] == $past(pin_channel_o[2:0]) + 3'h1) else $error("slot step wrong");
	a_stereo_stop: assert property ((frame_start_i && slot_arrangement_setting_i == 2'b00) ##1
		(slot_strobe_i && !frame_start_i)[*2] |=> pin_valid_o == 2'b00) else $error("stereo overran");

	// main scenarios
	c_frame: cover property (frame_start_i ##1 pin_valid_o[0]);
	c_read: cover property (reg_rd_i && reg_addr_i == 8'h17);
	c_serial: cover property (conv_src_o[0].src_class == SRS_SRC_SERIAL);
endmodule

bind srs_top srs_checker chk (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.slot_arrangement_setting_i, .frame_start_i, .slot_strobe_i, .pin_valid_o, .pin_channel_o, .conv_src_o, .route_o);
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srs_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module testbench;
	import srs_pkg::*;
	localparam int W = 24;
	// --------------------------------
	// signals
	// --------------------------------
	logic               clk_i, rst_b_i, reg_wr_i, reg_rd_i, frame_start_i, slot_strobe_i, rd_q;
	logic [7:0]         reg_addr_i, reg_wdata_i, reg_rdata_o, v, u, ex;
	logic [1:0]         slot_arrangement_setting_i, pin_valid_o;
	logic [5:0]         pin_channel_o;
	logic [2:0]         a0, a1;
	logic [8*W-1:0]     slot_data_i, serial_in_i;
	logic [4*W-1:0]     core_out_i, adc_i;
	logic [W-1:0]       pin0, pin1;
	logic [2*W-1:0]     conv_sample_o;
	srs_src_sel_s [1:0] conv_src_o;
	srs_route_s         route_o;
	logic [7:0]         exp_q[$];
	int                 n_errors, total_checks, seed, c, m, k, n;

	srs_top #(.SAMPLE_W(W)) uut (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.slot_arrangement_setting_i, .frame_start_i, .slot_strobe_i, .slot_data_i,
		.first_serial_output_pin_o(pin0), .second_serial_output_pin_o(pin1), .pin_valid_o, .pin_channel_o,
		.core_out_i, .adc_i, .serial_in_i, .conv_sample_o, .conv_src_o, .route_o);

	// clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// read results checked against queued notes
	always @(posedge clk_i) rd_q <= reg_rd_i;
	always @(negedge clk_i) begin
		if (rd_q === 1'b1) begin
			ex = exp_q.pop_front();
			`CHK("rdata", ex, reg_rdata_o)
		end
	end

	// --------------------------------
	// bus tasks and models
	// --------------------------------
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask

	task fill;
		for (int i = 0; i < 8; i++) begin
			slot_data_i[i*W +: W] <= W'($random(seed));
			serial_in_i[i*W +: W] <= W'($random(seed));
			if (i < 4) begin
				core_out_i[i*W +: W] <= W'($random(seed));
				adc_i[i*W +: W] <= W'($random(seed));
			end
		end
	endtask

	function automatic logic [W-1:0] src(input logic [3:0] s);
		if (s[3]) return serial_in_i[s[2:0]*W +: W];
		if (s[2]) return adc_i[s[1:0]*W +: W];
		return core_out_i[s[1:0]*W +: W];
	endfunction

	function automatic logic [4:0] cls(input logic [3:0] s);
		return {s[3] ? 2'b10 : {1'b0, s[2]}, s[3] ? s[2:0] : {1'b0, s[1:0]}};
	endfunction

	task summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		#100000;
		n_errors++;
		summarize;
	end

	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		seed = 32'hcaebab81;
		{rst_b_i, reg_wr_i, reg_rd_i, frame_start_i, slot_strobe_i, reg_addr_i, reg_wdata_i} = '0;
		{slot_arrangement_setting_i, slot_data_i, serial_in_i, core_out_i, adc_i} = '0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(8'h17, `SRS_START_SEL_RST);
		rd(8'h18, `SRS_CONV_SRC_RST);
		rd(8'h20, 8'h00);
		#1 `CHK("route", 12'h410, route_o)
		$display("test reset done");
		repeat (4) begin
			v = 8'($random(seed));
			u = 8'($random(seed));
			wr(8'h17, v);
			rd(8'h17, v);
			wr(8'h18, u);
			wr(8'h33, ~u);
			rd(8'h18, u);
			#1 `CHK("route", {v[3:0], u}, route_o)
		end
		$display("test regs done");
		for (c = 0; c < 16; c++) begin
			@(posedge clk_i);
			fill;
			wr(8'h18, {4'(15 - c), 4'(c)});
			repeat (2) @(posedge clk_i);
			#1 `CHK("src0", cls(4'(c)), conv_src_o[0])
			`CHK("src1", cls(4'(15 - c)), conv_src_o[1])
			`CHK("smp0", src(4'(c)), conv_sample_o[W-1:0])
			`CHK("smp1", src(4'(15 - c)), conv_sample_o[2*W-1:W])
		end
		$display("test conv done");
		for (m = 0; m < 4; m++) begin
			v = 8'($random(seed));
			wr(8'h17, v);
			@(posedge clk_i);
			slot_arrangement_setting_i <= m[1:0];
			frame_start_i <= 1'b1;
			fill;
			n = m == 0 ? 2 : m == 1 ? 4 : 8;
			for (k = 0; k < 10; k++) begin
				@(posedge clk_i);
				frame_start_i <= 1'b0;
				slot_strobe_i <= 1'b1;
				#1 `CHK("valid", k < n ? 2'b11 : 2'b00, pin_valid_o)
				if (k < n) begin
					a0 = {v[1:0], 1'b0} + 3'(k);
					a1 = {v[3:2], 1'b0} + 3'(k);
					`CHK("chan", {a1, a0}, pin_channel_o)
					`CHK("pin0", slot_data_i[a0*W +: W], pin0)
					`CHK("pin1", slot_data_i[a1*W +: W], pin1)
				end
			end
			@(posedge clk_i);
			slot_strobe_i <= 1'b0;
		end
		$display("test walker done");
		summarize;
	end
endmodule
`default_nettype wire
